// file: dual_clock_fifo_with_level_flags.sv
// Purpose: 18-bit FIFO with write and read ports, reinit, rewind and level flags
// Assumes: wr_clk and rd_clk are synchronous inputs sampled on ref_clk
// Notes:   Port clocks must be no faster than half of ref_clk to be seen
`timescale 1ns/100ps
`default_nettype none
`include "fifo_defs.svh"

// Summary of operation
// - Full reinit zeroes pointers and output register
// - Full reinit captures mode, default and method
// - Data reinit zeroes pointers, keeps configuration
// - Rewind resets read pointer only
// - Rewind forces empty or not-valid flag briefly
// - Mode pin at reinit, serial bit later
// - Write stores word, or loads offsets parallel
// - Serial shift loads one offset bit
// - Read presents next word, or offsets
// - Read data always driven; rd_data_oe follows the drive pin one cycle late
// - Access select at reinit picks default
// - Access select routes ports to offsets
// - Full flag or space-available by mode
// - Empty flag or data-valid by mode
// - Near-full low above capacity minus m
// - Near-empty low below offset n
// - Half flag shows above half capacity
// - Write and read data 18 bits
// - 127 pairs parallel, 1023 pairs serial
// - Fall-through first word after three edges
module dual_clock_fifo_with_level_flags #(
    parameter int DEPTH = `FIFO_DEPTH_SMALL
) (
    input  wire logic          ref_clk,
    input  wire logic          reset_n,
    input  wire logic          wr_clk,
    input  wire logic          rd_clk,
    input  wire logic          full_reinit_n,
    input  wire logic          data_only_reinit_n,
    input  wire logic          rewind_read_n,
    input  wire logic          mode_sel_serial_in,
    input  wire logic          wr_enable_n,
    input  wire logic          rd_enable_n,
    input  wire logic          serial_shift_en_n,
    input  wire logic          offset_access_sel_n,
    input  wire logic          q_drive_en_n,
    input  wire fifo_pkg::word_t wr_data,
    output var  fifo_pkg::word_t rd_data,
    output logic               rd_data_oe,
    output logic               full_space_avail_flag,
    output logic               empty_data_valid_flag,
    output logic               near_full_flag,
    output logic               near_empty_flag,
    output logic               half_level_flag
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [AW-1:0] OFF_LOW_V  = AW'(`FIFO_OFF_LOW);
    localparam logic [AW-1:0] OFF_HIGH_V = AW'(`FIFO_OFF_HIGH);
    localparam logic [CW-1:0] DEPTH_V    = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_V     = CW'(DEPTH / 2);
    localparam logic [1:0]    FALL_LAST  = 2'(`FIFO_FALL_EDGES - 1);
    localparam logic [1:0]    RETX_V     = 2'(`FIFO_RETX_EDGES);

    logic                  rstMeta;
    logic                  rstSyncN;
    logic                  wrClkPrev;
    logic                  rdClkPrev;
    logic                  wrEdge;
    logic                  rdEdge;
    logic                  reinitAny;
    fifo_pkg::cfg_s        cfgReg;
    logic [CW-1:0]         wrPtr;
    logic [CW-1:0]         rdPtr;
    logic [CW-1:0]         wordCount;
    logic                  memEmpty;
    logic                  memFull;
    fifo_pkg::word_t       mem [DEPTH];
    logic [AW-1:0]         emptyOff;
    logic [AW-1:0]         fullOff;
    logic                  wrOffSel;
    logic                  rdOffSel;
    logic                  outValid;
    logic [1:0]            fallCnt;
    logic [1:0]            retxCnt;
    fifo_pkg::flags_s      flagsNext;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Port clock edge detection; pins are already synchronous
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrClkPrev <= 1'b0;
            rdClkPrev <= 1'b0;
        end else begin
            wrClkPrev <= wr_clk;
            rdClkPrev <= rd_clk;
        end
    end

    assign wrEdge    = wr_clk & ~wrClkPrev;
    assign rdEdge    = rd_clk & ~rdClkPrev;
    assign reinitAny = ~full_reinit_n | ~data_only_reinit_n;

    // Occupancy from pointers carrying one extra wrap bit
    assign wordCount = wrPtr - rdPtr;
    assign memEmpty  = (wrPtr == rdPtr);
    assign memFull   = (wordCount == DEPTH_V);

    // Configuration, held across data-only reinit and rewind
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cfgReg <= '0;
        end else if (!full_reinit_n) begin
            cfgReg.fallThrough <= mode_sel_serial_in;
            cfgReg.serialProg  <= offset_access_sel_n;
        end
    end

    // Threshold offsets: defaults at full reinit, then loaded
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            emptyOff <= OFF_LOW_V;
            fullOff  <= OFF_LOW_V;
            wrOffSel <= 1'b0;
        end else if (!full_reinit_n) begin
            emptyOff <= offset_access_sel_n ? OFF_HIGH_V : OFF_LOW_V;
            fullOff  <= offset_access_sel_n ? OFF_HIGH_V : OFF_LOW_V;
            wrOffSel <= 1'b0;
        end else if (wrEdge && !offset_access_sel_n) begin
            if (!cfgReg.serialProg && !wr_enable_n) begin
                // Empty offset first, full offset on the next write
                if (wrOffSel) begin
                    fullOff <= wr_data[AW-1:0];
                end else begin
                    emptyOff <= wr_data[AW-1:0];
                end
                wrOffSel <= ~wrOffSel;
            end else if (cfgReg.serialProg && !serial_shift_en_n) begin
                // One bit per edge, entering at the top of the full offset
                {fullOff, emptyOff} <= {mode_sel_serial_in, fullOff, emptyOff[AW-1:1]};
            end
        end
    end

    // Storage array; no reset so it maps onto plain memory
    always_ff @(posedge ref_clk) begin
        if (!reinitAny && wrEdge && !wr_enable_n && offset_access_sel_n && !memFull) begin
            mem[wrPtr[AW-1:0]] <= wr_data;
        end
    end

    // Write pointer
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrPtr <= '0;
        end else if (reinitAny) begin
            wrPtr <= '0;
        end else if (wrEdge && !wr_enable_n && offset_access_sel_n && !memFull) begin
            wrPtr <= wrPtr + CW'(1);
        end
    end

    // Read side: pointer, output register, fall-through and rewind
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdPtr    <= '0;
            rd_data  <= '0;
            outValid <= 1'b0;
            fallCnt  <= '0;
            retxCnt  <= '0;
            rdOffSel <= 1'b0;
        end else if (reinitAny) begin
            rdPtr    <= '0;
            rd_data  <= '0;
            outValid <= 1'b0;
            fallCnt  <= '0;
            retxCnt  <= '0;
            rdOffSel <= 1'b0;
        end else if (rdEdge) begin
            if (!rewind_read_n) begin
                // Only the read side restarts; stored data is reread
                rdPtr    <= '0;
                outValid <= 1'b0;
                fallCnt  <= '0;
                retxCnt  <= RETX_V;
            end else if (retxCnt != 2'h0) begin
                retxCnt <= retxCnt - 2'h1;  // Reads wait out the rewind
            end else if (!rd_enable_n && !offset_access_sel_n) begin
                rd_data  <= rdOffSel ? fifo_pkg::word_t'(fullOff)
                                     : fifo_pkg::word_t'(emptyOff);
                rdOffSel <= ~rdOffSel;
            end else if (cfgReg.fallThrough) begin
                if (!outValid) begin
                    if (!memEmpty) begin
                        // First word falls through on the third edge
                        if (fallCnt == FALL_LAST) begin
                            rd_data  <= mem[rdPtr[AW-1:0]];
                            rdPtr    <= rdPtr + CW'(1);
                            outValid <= 1'b1;
                            fallCnt  <= '0;
                        end else begin
                            fallCnt <= fallCnt + 2'h1;
                        end
                    end
                end else if (!rd_enable_n) begin
                    if (!memEmpty) begin
                        rd_data <= mem[rdPtr[AW-1:0]];
                        rdPtr   <= rdPtr + CW'(1);
                    end else begin
                        outValid <= 1'b0;  // Word taken, nothing behind it
                    end
                end
            end else if (!rd_enable_n && !memEmpty) begin
                rd_data <= mem[rdPtr[AW-1:0]];
                rdPtr   <= rdPtr + CW'(1);
            end
        end
    end

    // Output drive follows the enable pin one cycle later
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rd_data_oe <= 1'b0;
        end else begin
            rd_data_oe <= ~q_drive_en_n;
        end
    end

    // Flag values, all active low as on the pins
    always_comb begin
        flagsNext.fullSpace  = cfgReg.fallThrough ? memFull : ~memFull;
        if (retxCnt != 2'h0) begin
            flagsNext.emptyValid = cfgReg.fallThrough;
        end else if (cfgReg.fallThrough) begin
            flagsNext.emptyValid = ~outValid;
        end else begin
            flagsNext.emptyValid = ~memEmpty;
        end
        flagsNext.nearFull  = ~(wordCount > (DEPTH_V - CW'(fullOff)));
        flagsNext.nearEmpty = ~(wordCount < CW'(emptyOff));
        flagsNext.halfLevel = ~(wordCount > HALF_V);
    end

    // Flag registers; values under reset match an empty buffer
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            full_space_avail_flag <= 1'b1;
            empty_data_valid_flag <= 1'b0;
            near_full_flag        <= 1'b1;
            near_empty_flag       <= 1'b0;
            half_level_flag       <= 1'b1;
        end else begin
            full_space_avail_flag <= flagsNext.fullSpace;
            empty_data_valid_flag <= flagsNext.emptyValid;
            near_full_flag        <= flagsNext.nearFull;
            near_empty_flag       <= flagsNext.nearEmpty;
            half_level_flag       <= flagsNext.halfLevel;
        end
    end

endmodule : dual_clock_fifo_with_level_flags
`default_nettype wire

// file: fifo_defs.svh
// Purpose: Constants for the dual-clock FIFO with level flags
// Assumes: Included by bare name by the FIFO design files
// Notes:   Counts are in edges of the sampled port clocks
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

`define FIFO_WORD_W      18
`define FIFO_DEPTH_SMALL 32768
`define FIFO_DEPTH_LARGE 65536
`define FIFO_OFF_LOW     127
`define FIFO_OFF_HIGH    1023
`define FIFO_FALL_EDGES  3
`define FIFO_RETX_EDGES  2

`endif

// file: fifo_pkg.sv
// Purpose: Types shared by the dual-clock FIFO design
// Assumes: Constants come from fifo_defs.svh
// Notes:   Nothing here is imported; use fifo_pkg::name
`default_nettype none
package fifo_pkg;

    typedef logic [17:0] word_t;

    // Configuration caught during full reinitialisation
    typedef struct packed {
        logic fallThrough;  // High selects fall-through timing
        logic serialProg;   // High selects serial offset loading
    } cfg_s;

    // Registered flag outputs, all active low
    typedef struct packed {
        logic fullSpace;
        logic emptyValid;
        logic nearFull;
        logic nearEmpty;
        logic halfLevel;
    } flags_s;

endpackage : fifo_pkg
`default_nettype wire

// file: fifo_props.sv
// Purpose: Port checks for the dual-clock FIFO
// Assumes: Bound to the FIFO top; one ref_clk domain
// Notes:   Mode-dependent flag levels are judged by the bench
`timescale 1ns/100ps
`default_nettype none
module fifo_props (
    input  wire logic            ref_clk,
    input  wire logic            reset_n,
    input  wire logic            rd_clk,
    input  wire logic            full_reinit_n,
    input  wire logic            data_only_reinit_n,
    input  wire logic            q_drive_en_n,
    input  wire fifo_pkg::word_t rd_data,
    input  wire logic            rd_data_oe,
    input  wire logic            near_full_flag,
    input  wire logic            near_empty_flag,
    input  wire logic            half_level_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Output enable follows its pin one cycle late
    property p_oe_on; !q_drive_en_n |=> rd_data_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe not raised");
    property p_oe_off; q_drive_en_n[*2] |-> !rd_data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe not released");
    // Either reinit empties the output register
    property p_full_clr; !full_reinit_n |=> rd_data == 18'h00000; endproperty
    a_full_clr: assert property (p_full_clr) else $error("full reinit kept data");
    property p_part_clr; (!data_only_reinit_n)[*3] |-> rd_data == 18'h00000; endproperty
    a_part_clr: assert property (p_part_clr) else $error("data reinit kept data");
    // Count is zero after two reinit cycles, so flags sit at the empty side
    property p_full_flags;
        (!full_reinit_n)[*2] |=> !near_empty_flag && half_level_flag && near_full_flag;
    endproperty
    a_full_flags: assert property (p_full_flags) else $error("flags not empty");
    property p_part_half; (!data_only_reinit_n)[*2] |=> half_level_flag; endproperty
    a_part_half: assert property (p_part_half) else $error("half flag wrong");
    property p_part_nf; (!data_only_reinit_n)[*2] |=> near_full_flag; endproperty
    a_part_nf: assert property (p_part_nf) else $error("near full wrong");
    // Read data moves only on a read-port rising edge or a reinit
    property p_rd_cause;
        $changed(rd_data) |-> ($past(rd_clk) && !$past(rd_clk, 2))
            || !$past(full_reinit_n) || !$past(data_only_reinit_n);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("data moved alone");
endmodule : fifo_props
`default_nettype wire

// file: port_agent.sv
// Purpose: Writer and reader logic on the two FIFO ports
// Assumes: Port clocks are slow pulses, one ref_clk high each
// Notes:   Port clocks stand low between transfers
`timescale 1ns/100ps
`default_nettype none
module port_agent (
    input  wire logic       ref_clk,
    output logic            wr_clk,
    output logic            rd_clk,
    output logic            wr_enable_n,
    output logic            rd_enable_n,
    output fifo_pkg::word_t wr_data
);
    // Idle: clocks low, enables off
    initial begin
        {wr_clk, rd_clk, wr_enable_n, rd_enable_n} = 4'h3;
        wr_data = 18'h00000;
    end

    // One write edge; word held over the taking edge, then inverted
    task automatic wr_pulse(input logic en, input fifo_pkg::word_t d);
        @(posedge ref_clk) #1;
        {wr_clk, wr_enable_n} = {1'b1, ~en};
        wr_data = d;
        @(posedge ref_clk) #1;
        {wr_clk, wr_enable_n} = 2'h1;
        wr_data = ~d;
    endtask : wr_pulse

    // One read edge, enabled or not
    task automatic rd_pulse(input logic en);
        @(posedge ref_clk) #1;
        {rd_clk, rd_enable_n} = {1'b1, ~en};
        @(posedge ref_clk) #1;
        {rd_clk, rd_enable_n} = 2'h1;
    endtask : rd_pulse
endmodule : port_agent
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the dual-clock FIFO
// Assumes: Depth 256 keeps flag counts short
// Notes:   Port traffic comes from the port agent
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic ref_clk, reset_n, full_reinit_n, data_only_reinit_n, rewind_read_n;
    logic mode_sel_serial_in, serial_shift_en_n, offset_access_sel_n, q_drive_en_n;
    logic wr_clk, rd_clk, wr_enable_n, rd_enable_n, rd_data_oe;
    logic full_space_avail_flag, empty_data_valid_flag;
    logic near_full_flag, near_empty_flag, half_level_flag;
    fifo_pkg::word_t wr_data, rd_data;
    int err_count, n_tests, cycles;

    dual_clock_fifo_with_level_flags #(.DEPTH(256)) u_dual_clock_fifo_with_level_flags (
        .ref_clk, .reset_n, .wr_clk, .rd_clk, .full_reinit_n, .data_only_reinit_n,
        .rewind_read_n, .mode_sel_serial_in, .wr_enable_n, .rd_enable_n, .serial_shift_en_n,
        .offset_access_sel_n, .q_drive_en_n, .wr_data, .rd_data, .rd_data_oe,
        .full_space_avail_flag, .empty_data_valid_flag, .near_full_flag, .near_empty_flag,
        .half_level_flag);
    port_agent u_port_agent (.ref_clk, .wr_clk, .rd_clk, .wr_enable_n, .rd_enable_n, .wr_data);

    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Flags trail the taking edge by one cycle
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic reinit(input logic full, input logic mode, input logic sel);
        @(posedge ref_clk) #1;
        {mode_sel_serial_in, offset_access_sel_n} = {mode, sel};
        if (full) full_reinit_n = 1'b0;
        else data_only_reinit_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 {full_reinit_n, data_only_reinit_n, mode_sel_serial_in, offset_access_sel_n} = 4'hD;
        settle();
    endtask : reinit

    task automatic t_reset;
        reinit(1'b1, 1'b0, 1'b0);
        check("data", rd_data, 18'h00000);
        check("empty", empty_data_valid_flag, 1'b0);
        check("full", full_space_avail_flag, 1'b1);
        check("nearEmpty", near_empty_flag, 1'b0);
        check("half", half_level_flag, 1'b1);
        check("oe", rd_data_oe, 1'b0);
    endtask : t_reset

    // Disabled write must not land; read past empty keeps last word
    task automatic t_stream;
        for (int i = 0; i < 3; i++) u_port_agent.wr_pulse(1'b1, 18'h2AAA0 + 18'(i));
        u_port_agent.wr_pulse(1'b0, 18'h15555);
        settle();
        check("empty", empty_data_valid_flag, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_port_agent.rd_pulse(1'b1);
            check("word", rd_data, 18'h2AAA0 + 18'(i < 3 ? i : 2));
        end
        settle();
        check("empty", empty_data_valid_flag, 1'b0);
    endtask : t_stream

    // Reads inside the rewind hold are ignored
    task automatic t_rewind;
        rewind_read_n = 1'b0;
        u_port_agent.rd_pulse(1'b0);
        rewind_read_n = 1'b1;
        // Flag register lags the rewind edge by one cycle; data is stored, so 0 is forced
        @(posedge ref_clk) #1;
        check("forced", empty_data_valid_flag, 1'b0);
        repeat (3) u_port_agent.rd_pulse(1'b1);
        check("again", rd_data, 18'h2AAA0);
        settle();
        check("empty", empty_data_valid_flag, 1'b1);
    endtask : t_rewind

    task automatic t_offsets;
        offset_access_sel_n = 1'b0;
        u_port_agent.wr_pulse(1'b1, 18'h00005);
        u_port_agent.wr_pulse(1'b1, 18'h000FA);
        for (int k = 0; k < 2; k++) begin
            u_port_agent.rd_pulse(1'b1);
            check("offset", rd_data, k == 0 ? 18'h00005 : 18'h000FA);
        end
        reinit(1'b0, 1'b0, 1'b1);
        check("cleared", rd_data, 18'h00000);
        offset_access_sel_n = 1'b0;
        u_port_agent.rd_pulse(1'b1);
        check("kept", rd_data, 18'h00005);
        u_port_agent.rd_pulse(1'b1);
        offset_access_sel_n = 1'b1;
        // n is 5, 256 - m is 6
        for (int i = 0; i < 7; i++) begin
            u_port_agent.wr_pulse(1'b1, 18'(i));
            settle();
            check("nearEmpty", near_empty_flag, i >= 4);
            check("nearFull", near_full_flag, i < 6);
        end
    endtask : t_offsets

    // Mid-run reset, then serial offsets; default 1023 wraps to 8 bits at depth 256
    task automatic t_serial;
        logic [15:0] bits;
        reset_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("rstData", rd_data, 18'h00000);
        check("rstEmpty", empty_data_valid_flag, 1'b0);
        reinit(1'b1, 1'b0, 1'b1);
        offset_access_sel_n = 1'b0;
        for (int k = 0; k < 2; k++) begin
            u_port_agent.rd_pulse(1'b1);
            check("default", rd_data, 18'h000FF);
        end
        // Full offset 4, empty offset 3, empty LSB shifted in first
        bits = 16'h0403;
        serial_shift_en_n = 1'b0;
        for (int j = 0; j < 16; j++) begin
            mode_sel_serial_in = bits[j];
            u_port_agent.wr_pulse(1'b0, 18'h00000);
        end
        serial_shift_en_n = 1'b1;
        u_port_agent.rd_pulse(1'b1);
        check("serialEmpty", rd_data, 18'h00003);
        u_port_agent.rd_pulse(1'b1);
        check("serialFull", rd_data, 18'h00004);
        offset_access_sel_n = 1'b1;
    endtask : t_serial

    task automatic t_fall;
        reinit(1'b1, 1'b1, 1'b0);
        check("valid", empty_data_valid_flag, 1'b1);
        check("space", full_space_avail_flag, 1'b0);
        u_port_agent.wr_pulse(1'b1, 18'h1ABCD);
        repeat (2) u_port_agent.rd_pulse(1'b0);
        settle();
        check("early", empty_data_valid_flag, 1'b1);
        u_port_agent.rd_pulse(1'b0);
        settle();
        check("word", rd_data, 18'h1ABCD);
        check("valid", empty_data_valid_flag, 1'b0);
        q_drive_en_n = 1'b0;
        settle();
        check("oe", rd_data_oe, 1'b1);
    endtask : t_fall

    initial begin
        {reset_n, full_reinit_n, data_only_reinit_n, rewind_read_n} = 4'h7;
        {mode_sel_serial_in, serial_shift_en_n, offset_access_sel_n, q_drive_en_n} = 4'h7;
        repeat (12) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_stream();
        t_rewind();
        t_offsets();
        t_serial();
        t_fall();
        print_verdict();
    end
endmodule : testbench

bind dual_clock_fifo_with_level_flags fifo_props u_fifo_props (.ref_clk, .reset_n, .rd_clk,
    .full_reinit_n, .data_only_reinit_n, .q_drive_en_n, .rd_data, .rd_data_oe,
    .near_full_flag, .near_empty_flag, .half_level_flag);
`default_nettype wire
